// ===== rtl/mhbi_host_port.sv
// Host port of the display controller: phase enables, transceiver
// direction, palette strobes, switch bits, power mode and interrupt.
// Assumes all pins are synchronous to clock (the master clock) and that
// the bus type select pin stays constant while out of reset.
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [R1] Raise the interrupt on each vertical sync rising edge.
// [R2] PC bus: interrupt pin floats while the emulation drive bit is clear.
// [R3] MCA bus: interrupt pin always works, drive bit ignored.
// [R4] Pick one of three dot clocks from the misc output field.
// [R5] The master clock sequences all register access cycles.
// [R6] Status register 0 bit 4 returns the monitor sense pin.
// [R7] Palette read strobe on reads of 3C6h, 3C8h, 3C9h; not 3C7h.
// [R8] Palette write strobe on any write to 3C6h through 3C9h.
// [R9] Outside logic decodes A19-A23 into the high address match.
// [R10] Latch the high address match for memory cycles, ignore on I/O.
// [R11] Address phase enable low selects address, high selects data.
// [R12] PC bus: address phase low while all four strobes are high.
// [R13] MCA bus: address phase low while command is high.
// [R14] Data phase enable is the inverse, floated during reset.
// [R15] Low byte direction low on reads, high on writes, floated in reset.
// [R16] High byte direction behaves the same for bits 8 to 15.
// [R17] Host holds address in address phase and data in data phase.
// [R18] Latch A16-A18 in address phase; switch bits 0-2 show their pins.
// [R19] Latch byte-high enable on command fall; switch bit 3 shows it.
// [R20] Switch bit 4 shows the high address match pin.
// [R21] Decode two power-down pins into normal, relax or retire.
// [R22] Reset returns all logic to its reset state.
// [R23] Bus type select low means MCA, high means PC bus.
// [R24] Switch bits 5 and 6 show memory/I-O select and card enable.
// [R25] Both power-down pins low means normal operation.
// [R26] Switch bits 0-2 and 4-6 are sampled from pins at the read itself.
module mhbi_host_port #(
    parameter int DOT_CLOCKS = 3
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Register port
    input wire logic [mhbi_pkg::ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    // Host bus control pins
    input wire logic hostBusTypeSelect,
    input wire mhbi_pkg::mhbi_strobe_s hostStrobe,
    input wire logic [15:0] hostAddr,
    input wire logic [2:0] highAddrBits,
    input wire logic byteHighEnableN,
    input wire logic highAddressMatch,
    input wire logic addressValidOrMemIoSelect,
    input wire logic refreshOrCardEnable,
    // Transceiver steering
    output mhbi_pkg::mhbi_xcvr_s xcvr,
    // Palette strobes
    output logic paletteReadStrobeN,
    output logic paletteWriteStrobeN,
    // Memory cycle qualification
    output logic memCycleHit,
    output logic [2:0] latchedHighAddr,
    output logic latchedByteHigh,
    // Video clocks and power mode
    input wire logic [DOT_CLOCKS-1:0] dotClockInputs,
    input wire logic monitorSenseInput,
    input wire logic [1:0] powerModeSelect,
    output logic selectedDotClock,
    output mhbi_pkg::mhbi_power_e powerMode,
    // Interrupt
    input wire logic vsync,
    output logic irqOut,
    output logic irqOe
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (DOT_CLOCKS != 3) begin : g_bad_clocks
        $error("DOT_CLOCKS must be 3 to match the two-bit select field");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        mhbi_pkg::mhbi_xcvr_s xcvr;
        logic palRdN;
        logic palWrN;
        logic cmdPrev;
        logic [15:0] addr;
        logic [2:0] highAddr;
        logic match;
        logic ioCycle;
        logic byteHigh;
        logic memHit;
        logic [7:0] misc;
        logic [7:0] emu;
        logic clearPulse;
        logic dotClk;
        mhbi_pkg::mhbi_power_e power;
        logic [7:0] rdData;
    } mhbi_port_s;

    mhbi_port_s state_q;
    mhbi_port_s state_d;
    logic pcBus;
    logic cmdActive;
    logic readCycle;
    logic ioRead;
    logic ioWrite;
    logic [1:0] clkSel;
    logic irqPending;

    // Bus mode and decoded command from the raw strobes.
    always_comb begin
        pcBus = hostBusTypeSelect; // [R23]
        if (pcBus) begin
            cmdActive = !(hostStrobe.memRdN && hostStrobe.memWrN
                && hostStrobe.ioRdN && hostStrobe.ioWrN); // [R12]
            readCycle = !hostStrobe.memRdN || !hostStrobe.ioRdN;
            ioRead = !hostStrobe.ioRdN && !state_q.ioCycle;
            ioWrite = !hostStrobe.ioWrN && !state_q.ioCycle;
        end else begin
            // In MCA the I/O read pin carries the command strobe.
            cmdActive = !hostStrobe.ioRdN; // [R13]
            readCycle = cmdActive && !hostStrobe.memRdN;
            ioRead = cmdActive && !hostStrobe.memRdN && state_q.ioCycle;
            ioWrite = cmdActive && !hostStrobe.memWrN && state_q.ioCycle;
        end
        clkSel = state_q.misc[mhbi_pkg::MISC_CLK_LO +: 2];
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Every field moves once per master clock edge.
    always_comb begin
        state_d = state_q; // [R5]
        state_d.cmdPrev = cmdActive;
        state_d.clearPulse = 1'b0;

        // Phase enables and transceiver direction.
        state_d.xcvr.addrPhaseEnN = cmdActive; // [R11]
        state_d.xcvr.dataPhaseEnN = !cmdActive; // [R14]
        state_d.xcvr.dataPhaseEnOe = 1'b1;
        state_d.xcvr.lowByteReadDirN = !readCycle; // [R15]
        state_d.xcvr.lowByteDirOe = 1'b1;
        state_d.xcvr.highByteReadDirN = !readCycle; // [R16]
        state_d.xcvr.highByteDirOe = 1'b1;

        // Address phase capture; the host holds it while the enable is low.
        if (!cmdActive) begin // [R17]
            state_d.addr = hostAddr;
            state_d.highAddr = highAddrBits; // [R18]
            state_d.match = highAddressMatch;
            // PC: low means a valid I/O address; MCA: low selects I/O.
            state_d.ioCycle = pcBus ? addressValidOrMemIoSelect
                                    : !addressValidOrMemIoSelect;
        end

        // Byte-high enable taken on the command's falling edge.
        if (cmdActive && !state_q.cmdPrev) begin
            state_d.byteHigh = !byteHighEnableN; // [R19]
        end

        // Memory qualification ignores the match on I/O cycles.
        if (pcBus) begin
            state_d.memHit = cmdActive && state_q.match && refreshOrCardEnable
                && !(hostStrobe.memRdN && hostStrobe.memWrN); // [R10]
        end else begin
            state_d.memHit = cmdActive && state_q.match && !state_q.ioCycle
                && refreshOrCardEnable; // [R10]
        end

        // Palette strobes; the status port is answered inside.
        state_d.palRdN = 1'b1;
        state_d.palWrN = 1'b1;
        if (ioRead && (state_q.addr == mhbi_pkg::PAL_MASK_PORT
                || state_q.addr == mhbi_pkg::PAL_WIDX_PORT
                || state_q.addr == mhbi_pkg::PAL_DATA_PORT)) begin
            state_d.palRdN = 1'b0; // [R7]
        end
        if (ioWrite && state_q.addr >= mhbi_pkg::PAL_MASK_PORT
                && state_q.addr <= mhbi_pkg::PAL_DATA_PORT) begin
            state_d.palWrN = 1'b0; // [R8]
        end

        // Dot clock select; the spare code falls back to the last input.
        state_d.dotClk = dotClockInputs[(clkSel > 2'h2) ? 2'h2 : clkSel]; // [R4]

        // Power mode decode; undefined codes fall back to retire.
        if (powerModeSelect == 2'b00) begin
            state_d.power = mhbi_pkg::PWR_NORMAL; // [R25]
        end else if (powerModeSelect == 2'b01) begin
            state_d.power = mhbi_pkg::PWR_RELAX; // [R21]
        end else begin
            state_d.power = mhbi_pkg::PWR_RETIRE; // [R21]
        end

        // Register writes.
        if (regWrite) begin
            if (regAddr == mhbi_pkg::MISC_OFS) begin
                state_d.misc = regWrData;
            end else if (regAddr == mhbi_pkg::EMU_OFS) begin
                state_d.emu = regWrData;
                state_d.emu[mhbi_pkg::EMU_CLEAR_BIT] = 1'b0;
                state_d.clearPulse = regWrData[mhbi_pkg::EMU_CLEAR_BIT];
            end
        end

        // Register reads: data valid only in the next cycle.
        state_d.rdData = 8'h00;
        if (regRead) begin
            if (regAddr == mhbi_pkg::SWITCH_OFS) begin
                // Pins are taken live at the read itself.
                state_d.rdData[2:0] = highAddrBits; // [R26] [R18]
                state_d.rdData[mhbi_pkg::SW_BHE_BIT] = state_q.byteHigh; // [R19]
                state_d.rdData[mhbi_pkg::SW_MATCH_BIT] = highAddressMatch; // [R20]
                state_d.rdData[mhbi_pkg::SW_MIO_BIT] = addressValidOrMemIoSelect; // [R24]
                state_d.rdData[mhbi_pkg::SW_CARD_BIT] = refreshOrCardEnable; // [R24]
            end else if (regAddr == mhbi_pkg::STATUS0_OFS) begin
                state_d.rdData[mhbi_pkg::STATUS0_SENSE_BIT] = monitorSenseInput; // [R6]
                state_d.rdData[mhbi_pkg::STATUS0_PEND_BIT] = irqPending;
            end else if (regAddr == mhbi_pkg::MISC_OFS) begin
                state_d.rdData = state_q.misc;
            end else if (regAddr == mhbi_pkg::EMU_OFS) begin
                state_d.rdData = state_q.emu;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Enables reset to zero so all steering pins but the address phase enable float in reset.
    always_ff @(posedge clock) begin
        if (reset) begin
            state_q <= '0; // [R22] [R14] [R15] [R16]
            state_q.xcvr.addrPhaseEnN <= 1'b0;
            state_q.xcvr.dataPhaseEnN <= 1'b1;
            state_q.xcvr.lowByteReadDirN <= 1'b1;
            state_q.xcvr.highByteReadDirN <= 1'b1;
            state_q.palRdN <= 1'b1;
            state_q.palWrN <= 1'b1;
            state_q.misc <= mhbi_pkg::MISC_RESET;
            state_q.emu <= mhbi_pkg::EMU_RESET;
            state_q.power <= mhbi_pkg::PWR_NORMAL;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Interrupt
    // ------------------------------------------------------------
    mhbi_irq_ctrl u_irq (
        .clock(clock),
        .reset(reset),
        .vsync(vsync),
        .pcBus(pcBus),
        .driveBit(state_q.emu[mhbi_pkg::EMU_DRIVE_BIT]),
        .enableBit(state_q.emu[mhbi_pkg::EMU_ENABLE_BIT]),
        .clearPulse(state_q.clearPulse),
        .irqOut(irqOut),
        .irqOe(irqOe),
        .pending(irqPending)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign xcvr = state_q.xcvr;
    assign paletteReadStrobeN = state_q.palRdN;
    assign paletteWriteStrobeN = state_q.palWrN;
    assign memCycleHit = state_q.memHit;
    assign latchedHighAddr = state_q.highAddr;
    assign latchedByteHigh = state_q.byteHigh;
    assign selectedDotClock = state_q.dotClk;
    assign powerMode = state_q.power;
    assign regRdData = state_q.rdData;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_cmdStart;
        !cmdActive ##1 cmdActive;
    endsequence

    sequence s_switchRead;
        regRead && regAddr == mhbi_pkg::SWITCH_OFS;
    endsequence

    property p_addr_phase;
        @(posedge clock) disable iff (reset)
            s_cmdStart |=> (xcvr.addrPhaseEnN && !xcvr.dataPhaseEnN);
    endproperty
    a_addr_phase: assert property (p_addr_phase) else $error("data phase not entered"); // [R11]

    property p_pc_idle;
        @(posedge clock) disable iff (reset)
            (pcBus && hostStrobe == 4'hf) |=> !xcvr.addrPhaseEnN;
    endproperty
    a_pc_idle: assert property (p_pc_idle) else $error("pc idle not address phase"); // [R12]

    property p_mca_cmd;
        @(posedge clock) disable iff (reset)
            (!pcBus && !hostStrobe.ioRdN) |=> xcvr.addrPhaseEnN;
    endproperty
    a_mca_cmd: assert property (p_mca_cmd) else $error("mca command not data phase"); // [R13]

    property p_inverse;
        @(posedge clock) disable iff (reset)
            xcvr.dataPhaseEnOe |-> (xcvr.dataPhaseEnN == !xcvr.addrPhaseEnN);
    endproperty
    a_inverse: assert property (p_inverse) else $error("data enable not inverse"); // [R14]

    property p_float_after_reset;
        @(posedge clock) reset |=> (!xcvr.dataPhaseEnOe && !xcvr.lowByteDirOe
            && !xcvr.highByteDirOe);
    endproperty
    a_float_after_reset: assert property (p_float_after_reset) else $error("pins driven in reset"); // [R15]

    property p_dir_read;
        @(posedge clock) disable iff (reset)
            readCycle |=> (!xcvr.lowByteReadDirN && !xcvr.highByteReadDirN);
    endproperty
    a_dir_read: assert property (p_dir_read) else $error("direction not read"); // [R16]

    property p_pal_state_port;
        @(posedge clock) disable iff (reset)
            (state_q.addr == mhbi_pkg::PAL_STATE_PORT) |=> paletteReadStrobeN;
    endproperty
    a_pal_state_port: assert property (p_pal_state_port) else $error("strobe on 3C7h read"); // [R7]

    property p_pal_write;
        @(posedge clock) disable iff (reset)
            (ioWrite && state_q.addr == mhbi_pkg::PAL_DATA_PORT) |=> !paletteWriteStrobeN;
    endproperty
    a_pal_write: assert property (p_pal_write) else $error("palette write missed"); // [R8]

    property p_switch_read;
        logic [2:0] bits;
        @(posedge clock) disable iff (reset)
            (s_switchRead, bits = highAddrBits) |=> (regRdData[2:0] == bits
                && regRdData[7] == 1'b0);
    endproperty
    a_switch_read: assert property (p_switch_read) else $error("switch bits wrong"); // [R26]

    property p_sense_read;
        @(posedge clock) disable iff (reset)
            (regRead && regAddr == mhbi_pkg::STATUS0_OFS)
                |=> regRdData[mhbi_pkg::STATUS0_SENSE_BIT] == $past(monitorSenseInput);
    endproperty
    a_sense_read: assert property (p_sense_read) else $error("sense bit wrong"); // [R6]

    property p_power_normal;
        @(posedge clock) disable iff (reset)
            (powerModeSelect == 2'b00) |=> powerMode == mhbi_pkg::PWR_NORMAL;
    endproperty
    a_power_normal: assert property (p_power_normal) else $error("power mode wrong"); // [R25]

endmodule // mhbi_host_port

`default_nettype wire

// ===== rtl/mhbi_pkg.sv
// Shared constants and types for the muxed host bus interface.
// Assumes a single 200 MHz clock and a synchronous active-high reset.
package mhbi_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] SWITCH_OFS = 8'h01;
    localparam logic [7:0] STATUS0_OFS = 8'h02;
    localparam logic [7:0] MISC_OFS = 8'h03;
    localparam logic [7:0] EMU_OFS = 8'h14;
    localparam logic [7:0] MISC_RESET = 8'h00;
    localparam logic [7:0] EMU_RESET = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int EMU_DRIVE_BIT = 7;
    localparam int EMU_CLEAR_BIT = 5;
    localparam int EMU_ENABLE_BIT = 4;
    localparam int MISC_CLK_LO = 2;
    localparam int STATUS0_SENSE_BIT = 4;
    localparam int STATUS0_PEND_BIT = 7;
    localparam int SW_BHE_BIT = 3;
    localparam int SW_MATCH_BIT = 4;
    localparam int SW_MIO_BIT = 5;
    localparam int SW_CARD_BIT = 6;

    // ------------------------------------------------------------
    // External palette ports
    // ------------------------------------------------------------
    localparam logic [15:0] PAL_MASK_PORT = 16'h03c6;
    localparam logic [15:0] PAL_STATE_PORT = 16'h03c7;
    localparam logic [15:0] PAL_WIDX_PORT = 16'h03c8;
    localparam logic [15:0] PAL_DATA_PORT = 16'h03c9;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PWR_NORMAL = 2'b00,
        PWR_RELAX = 2'b01,
        PWR_RETIRE = 2'b10
    } mhbi_power_e;

    // Strobes of the multiplexed host bus, all active low.
    typedef struct packed {
        logic memRdN;
        logic memWrN;
        logic ioRdN;
        logic ioWrN;
    } mhbi_strobe_s;

    // Transceiver steering outputs with their enables.
    typedef struct packed {
        logic addrPhaseEnN;
        logic dataPhaseEnN;
        logic dataPhaseEnOe;
        logic lowByteReadDirN;
        logic lowByteDirOe;
        logic highByteReadDirN;
        logic highByteDirOe;
    } mhbi_xcvr_s;

endpackage

// ===== rtl/mhbi_irq_ctrl.sv
// Vertical-sync interrupt with its tri-state emulation option.
// Assumes vsync is synchronous to clock and already active high.
`timescale 1ns/1ps
`default_nettype none

module mhbi_irq_ctrl (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Controls
    input wire logic vsync,
    input wire logic pcBus,
    input wire logic driveBit,
    input wire logic enableBit,
    input wire logic clearPulse,
    // Interrupt pin and state
    output logic irqOut,
    output logic irqOe,
    output logic pending
);

    typedef struct packed {
        logic vsyncPrev;
        logic pending;
        logic out;
        logic oe;
    } mhbi_irq_s;

    mhbi_irq_s state_q;
    mhbi_irq_s state_d;
    logic risingVsync;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // A new edge in the clearing cycle keeps the flag set.
    always_comb begin
        state_d = state_q;
        risingVsync = vsync && !state_q.vsyncPrev;
        state_d.vsyncPrev = vsync;
        if (risingVsync) begin
            state_d.pending = 1'b1; // [R1]
        end else if (clearPulse) begin
            state_d.pending = 1'b0;
        end
        state_d.out = 1'b0;
        state_d.oe = 1'b0;
        if (pcBus) begin
            // The drive bit floats the pin whatever the enable says.
            if (driveBit && enableBit) begin // [R2]
                state_d.oe = 1'b1;
                state_d.out = state_d.pending;
            end
        end else begin
            // Open-drain style: pulled low only while a request stands.
            if (enableBit && state_d.pending) begin // [R3]
                state_d.oe = 1'b1;
                state_d.out = 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_q <= '0; // [R22]
        end else begin
            state_q <= state_d;
        end
    end

    assign irqOut = state_q.out;
    assign irqOe = state_q.oe;
    assign pending = state_q.pending;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_irq_pc_float;
        @(posedge clock) disable iff (reset)
            (pcBus && !driveBit) |=> !irqOe;
    endproperty
    a_irq_pc_float: assert property (p_irq_pc_float) else $error("irq driven with drive bit clear"); // [R2]

    property p_irq_mca_low;
        @(posedge clock) disable iff (reset)
            (!pcBus && enableBit && !clearPulse && $rose(vsync)) ##1 (!pcBus && enableBit)
                |-> (irqOe && !irqOut);
    endproperty
    a_irq_mca_low: assert property (p_irq_mca_low) else $error("mca irq not pulled low"); // [R3]

    property p_irq_edge_sets;
        @(posedge clock) disable iff (reset)
            $rose(vsync) |=> pending;
    endproperty
    a_irq_edge_sets: assert property (p_irq_edge_sets) else $error("vsync edge lost"); // [R1]

endmodule // mhbi_irq_ctrl

`default_nettype wire

// ===== tb/mhbi_host_model.sv
// Host CPU bus model: strobes, multiplexed address and byte-high enable.
// Assumes the bench calls its tasks from the clock domain of the port.
`timescale 1ns/1ps
`default_nettype none
module mhbi_host_model (
    // Clock
    input wire logic clock,
    // Bus pins
    output mhbi_pkg::mhbi_strobe_s hostStrobe,
    output logic [15:0] hostAddr,
    output logic byteHighEnableN
);
    // Idle bus at time zero: no command is active.
    initial begin
        hostStrobe = 4'hf;
        hostAddr = 16'h0000;
        byteHighEnableN = 1'h1;
    end
    // One cycle of address phase, then the command stays until stop.
    task automatic start(input logic [3:0] s, input logic [15:0] a, input logic bhe);
        @(posedge clock);
        hostAddr <= a;
        byteHighEnableN <= bhe;
        @(posedge clock);
        hostStrobe <= s;
    endtask
    // Released lines flip, so a stale address never passes for a valid one.
    task automatic stop();
        @(posedge clock);
        hostStrobe <= 4'hf;
        hostAddr <= ~hostAddr;
        byteHighEnableN <= ~byteHighEnableN;
    endtask
endmodule // mhbi_host_model
`default_nettype wire

// ===== tb/tb_muxed_host_bus_interface.sv
// Self-checking bench for the host port of the display controller.
// Assumes the package and the host bus model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_muxed_host_bus_interface;
    // ------------------------------------------------------------
    // Stimulus, instances and checking
    // ------------------------------------------------------------
    logic clock = 1'h0, reset = 1'h1, regWrite = 1'h0, regRead = 1'h0, pcBus = 1'h1;
    logic mio = 1'h0, card = 1'h1, sense = 1'h0, vsync = 1'h0, rdSeen = 1'h0;
    logic match = 1'h1;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, expQ[$];
    logic [2:0] hab = 3'h0, dots = 3'h0, lha;
    logic [1:0] pwr = 2'h0;
    logic pRd, pWr, hit, irqOut, irqOe, dotSel, bheN, lbh;
    logic [15:0] addr;
    logic [31:0] r;
    mhbi_pkg::mhbi_strobe_s strb;
    mhbi_pkg::mhbi_xcvr_s xcvr;
    mhbi_pkg::mhbi_power_e pm;
    int mismatches = 0, num_checks = 0, i;
    mhbi_host_model mhbi_host_model_i (.clock(clock), .hostStrobe(strb), .hostAddr(addr),
        .byteHighEnableN(bheN));
    mhbi_host_port mhbi_host_port_i (.clock(clock), .reset(reset), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .hostBusTypeSelect(pcBus), .hostStrobe(strb), .hostAddr(addr), .highAddrBits(hab),
        .byteHighEnableN(bheN), .highAddressMatch(match), .addressValidOrMemIoSelect(mio),
        .refreshOrCardEnable(card), .xcvr(xcvr), .paletteReadStrobeN(pRd),
        .paletteWriteStrobeN(pWr), .memCycleHit(hit), .latchedHighAddr(lha),
        .latchedByteHigh(lbh),
        .dotClockInputs(dots), .monitorSenseInput(sense), .powerModeSelect(pwr),
        .selectedDotClock(dotSel), .powerMode(pm), .vsync(vsync), .irqOut(irqOut), .irqOe(irqOe));
    // Free-running master clock.
    always #2.5 clock = ~clock;
    task automatic chk(input string n, input logic [7:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // A read notes its expected answer; the watcher below compares it.
    task automatic acc(input logic isWr, input logic [7:0] a, d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWrite <= isWr;
        regRead <= !isWr;
        if (!isWr) expQ.push_back(d);
        @(posedge clock);
        regWrite <= 1'h0;
        regRead <= 1'h0;
    endtask
    // Read data stand one cycle only, so they are taken at that edge.
    always @(posedge clock) begin
        if (rdSeen) chk("read data", regRdData, expQ.pop_front());
        rdSeen <= regRead;
    end
    task automatic rst(input logic bus);
        @(posedge clock);
        reset <= 1'h1;
        pcBus <= bus;
        w(1);
        chk("data enable oe", xcvr.dataPhaseEnOe, 8'h00);
        chk("low dir oe", xcvr.lowByteDirOe, 8'h00);
        chk("high dir oe", xcvr.highByteDirOe, 8'h00);
        chk("irq oe", irqOe, 8'h00);
        repeat (2) @(posedge clock);
        reset <= 1'h0;
    endtask
    task automatic vs();
        @(posedge clock);
        vsync <= 1'h1;
        repeat (4) @(posedge clock);
        vsync <= 1'h0;
        #1;
    endtask
    task automatic end_sim();
        $display("Checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // A hang counts as a mismatch; the run needs well under this span.
    initial begin
        repeat (3000) @(posedge clock);
        mismatches++;
        end_sim();
    end
    // Main sequence: PC bus, registers, clocks, power, interrupt, then MCA.
    initial begin
        r = $urandom(32'h8d49c031);
        rst(1'h1);
        for (i = 0; i < 16; i++) begin
            mhbi_host_model_i.start(~(4'h1 << i[3:2]), 16'h03c6 + 16'(i[1:0]), 1'h1);
            w(1);
            chk("address enable", xcvr.addrPhaseEnN, 8'h01);
            chk("data enable", xcvr.dataPhaseEnN, 8'h00);
            chk("low dir", xcvr.lowByteReadDirN, !i[2]);
            chk("high dir", xcvr.highByteReadDirN, !i[2]);
            chk("palette read", pRd, !(i[3:2] == 1 && i[1:0] != 1));
            chk("palette write", pWr, i[3:2] != 0);
            chk("memory hit", hit, i[3]);
            mhbi_host_model_i.stop();
            w(1);
            chk("address phase", xcvr.addrPhaseEnN, 8'h00);
        end
        r = $urandom;
        mhbi_host_model_i.start(4'hd, 16'h0100, r[7]);
        w(1);
        mhbi_host_model_i.stop();
        @(posedge clock);
        {hab, match, mio, card, sense} <= r[6:0];
        acc(1'h0, mhbi_pkg::SWITCH_OFS, {1'h0, r[1], r[2], r[3], !r[7], r[6:4]});
        acc(1'h0, mhbi_pkg::STATUS0_OFS, {3'h0, r[0], 4'h0});
        acc(1'h0, 8'hff, 8'h00);
        for (i = 0; i < 4; i++) begin
            r = $urandom;
            acc(1'h1, mhbi_pkg::MISC_OFS, 8'(i << 2));
            @(posedge clock);
            dots <= r[2:0];
            pwr <= i[1:0];
            w(3);
            chk("dot clock", dotSel, dots[(i == 3) ? 2 : i]);
            chk("power mode", pm, (i == 3) ? 8'h02 : 8'(i));
        end
        acc(1'h1, mhbi_pkg::EMU_OFS, 8'h90);
        vs();
        chk("irq oe", irqOe, 8'h01);
        chk("irq level", irqOut, 8'h01);
        acc(1'h1, mhbi_pkg::EMU_OFS, 8'hb0);
        w(2);
        chk("irq cleared", irqOut, 8'h00);
        acc(1'h1, mhbi_pkg::EMU_OFS, 8'h10);
        vs();
        chk("irq floated", irqOe, 8'h00);
        rst(1'h0);
        acc(1'h0, mhbi_pkg::STATUS0_OFS, {3'h0, sense, 4'h0});
        for (i = 0; i < 2; i++) begin
            mhbi_host_model_i.start(i[0] ? 4'hd : 4'hb, 16'h0100, 1'h1);
            w(1);
            chk("command phase", xcvr.addrPhaseEnN, 8'(i));
            chk("latched address", {lbh, lha}, {1'h0, hab});
            mhbi_host_model_i.stop();
            w(1);
        end
        acc(1'h1, mhbi_pkg::EMU_OFS, 8'h10);
        vs();
        chk("irq mca oe", irqOe, 8'h01);
        chk("irq mca level", irqOut, 8'h00);
        end_sim();
    end
endmodule // tb_muxed_host_bus_interface
`default_nettype wire
